// >>> verilog/bpc_defines.vh
// constants for the bus probe capture and stimulus block
`ifndef BPC_DEFINES_VH
`define BPC_DEFINES_VH

// channel group widths
`define BPC_ADDR_W 24
`define BPC_DATA_W 16
`define BPC_USER_W 12
`define BPC_STAT_W 8
`define BPC_CLK_W 8

// latch clock positions within the clock group
`define BPC_CLK_ADDR_A 2
`define BPC_CLK_ADDR_B 3
`define BPC_CLK_STAT_A 4
`define BPC_CLK_STAT_B 5

// stimulus source select codes
`define BPC_SRC_TRIG 2'h0
`define BPC_SRC_WIN 2'h1
`define BPC_SRC_SEQ 2'h2

// halt source select codes
`define BPC_HALT_TPOINT 1'b0
`define BPC_HALT_MDONE 1'b1

// stimulus pulse timing: width in ns and clock period in ns
`define BPC_PULSE_NS 5000
`define BPC_MCLK_NS 25
`define BPC_PULSE_CYC (`BPC_PULSE_NS / `BPC_MCLK_NS)

// fifo geometry
`define BPC_FIFO_DEPTH 16

// arbitrary identification values
`define BPC_PROBE_ID 8'h5A
`endif

// >>> verilog/bpc_probe.v
// probe front end: channel capture, clock latching, halt and stimulus outputs
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
`include "bpc_defines.vh"

// ----------------------------------------------------------------------------
// fifo: flip-flop storage, valid/ready on both sides
// ----------------------------------------------------------------------------
module bpc_fifo #(
    parameter WIDTH = 68,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    // clock and reset
    input wire mclk,
    input wire srst,
    // fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // drain side
    output wire out_valid,
    input wire out_ready,
    output reg [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1]; // storage words
    reg [AW-1:0] wr_ptr; // write index
    reg [AW-1:0] rd_ptr; // read index
    reg [AW:0] count; // words held
    wire push; // word accepted
    wire pop; // word drained

    assign in_ready = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // storage write
    always @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // a full buffer refuses the push; the caller decides what the loss means
    // pointers and fill level
    always @(posedge mclk) begin
        if (srst) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end

    // read data is the head word, straight from the storage flops
    always @* begin
        out_data = mem[rd_ptr];
    end
endmodule

// ----------------------------------------------------------------------------
// top: probe front end
// ----------------------------------------------------------------------------
module bpc_probe (
    // clock and reset
    input wire mclk,
    input wire srst,
    // target channel pins
    input wire [`BPC_ADDR_W-1:0] tgt_addr,
    input wire [`BPC_DATA_W-1:0] tgt_data,
    input wire [`BPC_USER_W-1:0] tgt_user,
    input wire [`BPC_STAT_W-1:0] tgt_stat,
    input wire [`BPC_CLK_W-1:0] tgt_clk,
    // latch clock configuration from the interface module (index 0..3 = clocks 2..5)
    input wire [3:0] clk_enable,
    input wire [3:0] clk_falling,
    input wire [7:0] module_id,
    // trace control from the analyzer
    input wire trace_start,
    input wire ev_trigger,
    input wire ev_window,
    input wire ev_sequencer,
    input wire ev_tpoint,
    input wire ev_mdone,
    // trace configuration
    input wire [1:0] stim_src,
    input wire stim_enable,
    input wire stim_repeat,
    input wire stim_handshake,
    input wire halt_enable,
    input wire halt_src,
    // target handshake pins
    input wire ack_n_in,
    output wire halt_n_out,
    output wire halt_n_oe,
    output wire stim_n_out,
    output wire stim_n_oe,
    // analyzer stream
    output wire anl_valid,
    input wire anl_ready,
    output wire [67:0] anl_word,
    output wire cap_overflow,
    output wire [7:0] probe_id,
    output wire [7:0] probe_module_id,
    // status
    output wire halt_active,
    output wire stim_active
);
    localparam CW = 68; // captured word width
    localparam PCW = 8; // pulse counter width
    // terminal count cut to the counter's width on purpose; 199 fits in eight bits
    localparam integer PULSE_LAST_I = `BPC_PULSE_CYC - 1;
    localparam [PCW-1:0] PULSE_LAST = PULSE_LAST_I[PCW-1:0];

    // ------------------------------------------------------------------------
    // pin synchronisers: two flops before any logic
    // ------------------------------------------------------------------------
    // pins are asynchronous to mclk: only the second stage may read the first
    reg [CW-1:0] pin_s1; // first stage, read only by pin_s2
    reg [CW-1:0] pin_s2; // usable samples
    reg [1:0] ack_sync; // ack synchroniser
    reg [`BPC_CLK_W-1:0] clk_prev; // previous clock samples for edge find
    wire ack_seen; // acknowledge active, after sync

    always @(posedge mclk) begin
        if (srst) begin
            pin_s1 <= {CW{1'b0}};
            pin_s2 <= {CW{1'b0}};
            ack_sync <= 2'b11;
            clk_prev <= {`BPC_CLK_W{1'b0}};
        end else begin
            pin_s1 <= {tgt_clk, tgt_stat, tgt_user, tgt_data, tgt_addr};
            pin_s2 <= pin_s1;
            ack_sync <= {ack_sync[0], ack_n_in};
            clk_prev <= pin_s2[CW-1 -: `BPC_CLK_W];
        end
    end
    assign ack_seen = ~ack_sync[1];

    // ------------------------------------------------------------------------
    // latch clock edges: polarity, enable, OR per group
    // ------------------------------------------------------------------------
    wire [`BPC_CLK_W-1:0] clk_now; // current clock samples
    wire [3:0] lclk_now; // latch clocks 2..5 now
    wire [3:0] lclk_was; // latch clocks 2..5 before
    wire [3:0] lclk_edge; // selected active edge, enabled
    wire addr_load; // address latch load
    wire stat_load; // status latch load

    assign clk_now = pin_s2[CW-1 -: `BPC_CLK_W];
    assign lclk_now = clk_now[`BPC_CLK_STAT_B:`BPC_CLK_ADDR_A];
    assign lclk_was = clk_prev[`BPC_CLK_STAT_B:`BPC_CLK_ADDR_A];
    // edges are found on the synced copy, so a load lags its pin by two to three cycles
    // falling selects 1->0, otherwise 0->1
    assign lclk_edge = clk_enable & ((lclk_now ^ clk_falling) & ~(lclk_was ^ clk_falling));
    assign addr_load = lclk_edge[0] | lclk_edge[1];
    assign stat_load = lclk_edge[2] | lclk_edge[3];

    // ------------------------------------------------------------------------
    // group latches: address and status hold, data and user pass
    // ------------------------------------------------------------------------
    reg [`BPC_ADDR_W-1:0] addr_latch; // held address
    reg [`BPC_STAT_W-1:0] stat_latch; // held status
    reg [CW-1:0] cap_word; // word presented to fifo
    reg cap_valid; // word pending

    always @(posedge mclk) begin
        if (srst) begin
            addr_latch <= {`BPC_ADDR_W{1'b0}};
            stat_latch <= {`BPC_STAT_W{1'b0}};
        end else begin
            if (addr_load) begin
                addr_latch <= pin_s2[`BPC_ADDR_W-1:0];
            end
            if (stat_load) begin
                stat_latch <= pin_s2[CW-`BPC_CLK_W-1 -: `BPC_STAT_W];
            end
        end
    end

    // one word per mclk; all eight clocks and data/user go straight through
    always @(posedge mclk) begin
        if (srst) begin
            cap_word <= {CW{1'b0}};
            cap_valid <= 1'b0;
        end else begin
            cap_word <= {clk_now, stat_latch, pin_s2[`BPC_ADDR_W+`BPC_DATA_W+`BPC_USER_W-1:`BPC_ADDR_W],
                addr_latch};
            cap_valid <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // capture buffer toward the analyzer
    // ------------------------------------------------------------------------
    wire fifo_in_ready; // fifo can accept
    reg overflow; // sticky: word dropped while full

    bpc_fifo #(.WIDTH(CW), .DEPTH(`BPC_FIFO_DEPTH), .AW(4)) u_fifo (
        .mclk(mclk),
        .srst(srst),
        .in_valid(cap_valid),
        .in_ready(fifo_in_ready),
        .in_data(cap_word),
        .out_valid(anl_valid),
        .out_ready(anl_ready),
        .out_data(anl_word)
    );

    // the target cannot be stalled, so a full buffer can only report loss
    always @(posedge mclk) begin
        if (srst) begin
            overflow <= 1'b0;
        end else if (cap_valid && !fifo_in_ready) begin
            overflow <= 1'b1;
        end else if (trace_start) begin
            overflow <= 1'b0;
        end
    end
    assign cap_overflow = overflow;

    // probe code is a fixed arbitrary value; the module code comes from its own straps
    // identification toward the analyzer
    assign probe_id = `BPC_PROBE_ID;
    assign probe_module_id = module_id;

    // ------------------------------------------------------------------------
    // halt output
    // ------------------------------------------------------------------------
    reg halt; // halt held
    wire halt_ev; // selected halt event

    assign halt_ev = halt_enable & ((halt_src == `BPC_HALT_MDONE) ? ev_mdone : ev_tpoint);

    // set wins over the new-trace release in the same cycle
    always @(posedge mclk) begin
        if (srst) begin
            halt <= 1'b0;
        end else if (halt_ev) begin
            halt <= 1'b1;
        end else if (trace_start) begin
            halt <= 1'b0;
        end
    end
    // the pin only ever pulls low; when released the target's pull-up sets the level
    assign halt_n_out = 1'b0;
    assign halt_n_oe = halt;
    assign halt_active = halt;

    // ------------------------------------------------------------------------
    // stimulus output
    // ------------------------------------------------------------------------
    reg stim; // stimulus asserted
    reg fired; // single mode already used this trace
    reg [PCW-1:0] pulse_cnt; // pulse width counter
    reg stim_src_ev; // selected source event
    wire stim_req; // request allowed to fire

    always @* begin
        case (stim_src)
            `BPC_SRC_TRIG: stim_src_ev = ev_trigger;
            `BPC_SRC_WIN: stim_src_ev = ev_window;
            `BPC_SRC_SEQ: stim_src_ev = ev_sequencer;
            default: stim_src_ev = 1'b0;
        endcase
    end

    // limitation: acknowledge is seen two cycles late, so a target must release it promptly
    // disabled blocks everything; single allows one firing per trace
    assign stim_req = stim_enable & stim_src_ev & (stim_repeat | ~fired);

    always @(posedge mclk) begin
        if (srst) begin
            stim <= 1'b0;
            fired <= 1'b0;
            pulse_cnt <= {PCW{1'b0}};
        end else if (trace_start) begin
            // an occurrence in the starting cycle belongs to the new trace, so it still fires
            stim <= stim_enable & stim_src_ev;
            fired <= stim_enable & stim_src_ev;
            pulse_cnt <= {PCW{1'b0}};
        end else if (!stim_enable) begin
            stim <= 1'b0;
            pulse_cnt <= {PCW{1'b0}};
        end else if (stim_req) begin
            // a new occurrence restarts the pulse timer
            stim <= 1'b1;
            fired <= 1'b1;
            pulse_cnt <= {PCW{1'b0}};
        end else if (stim && !stim_handshake) begin
            if (pulse_cnt == PULSE_LAST) begin
                stim <= 1'b0;
                pulse_cnt <= {PCW{1'b0}};
            end else begin
                pulse_cnt <= pulse_cnt + 1'b1;
            end
        end else if (stim && stim_repeat && ack_seen) begin
            stim <= 1'b0;
        end
        // single handshake: only the next trace or clearing stim_enable releases it
    end
    assign stim_n_out = 1'b0;
    assign stim_n_oe = stim;
    assign stim_active = stim;
endmodule
`default_nettype wire

// >>> dv/bpc_tgt_model.sv
// target side model: acknowledges a held stimulus after a set lag
`timescale 1ns/10ps
`default_nettype none
module bpc_tgt_model (
    // clock
    input wire logic mclk,
    // bench control
    input wire logic ack_on,
    input wire logic [7:0] lag,
    // target pins
    input wire logic stim_w,
    output logic ack_n
);
    logic [7:0] cnt; // cycles the stimulus has been seen low
    // the bench keeps ack_on low through reset, which settles both registers
    // ack is pulled high when released; low only while answering
    always @(posedge mclk) begin
        if (stim_w || !ack_on) begin
            cnt <= 8'h00;
            ack_n <= 1'b1;
        end else if (cnt == lag) begin
            ack_n <= 1'b0;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule
`default_nettype wire

// >>> dv/bpc_probe_monitor.sv
// assertion checker for the probe front end, bound to its top
`timescale 1ns/10ps
`default_nettype none
`include "bpc_defines.vh"
module bpc_probe_monitor (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // trace control and configuration
    input wire logic trace_start,
    input wire logic ev_trigger,
    input wire logic ev_window,
    input wire logic ev_sequencer,
    input wire logic ev_tpoint,
    input wire logic ev_mdone,
    input wire logic [1:0] stim_src,
    input wire logic stim_enable,
    input wire logic stim_repeat,
    input wire logic stim_handshake,
    input wire logic halt_enable,
    input wire logic halt_src,
    // target pins
    input wire logic ack_n_in,
    input wire logic halt_n_oe,
    input wire logic stim_n_oe
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    wire sel_ev; // selected stimulus source fired
    wire halt_ev; // selected halt source fired
    logic [15:0] run; // cycles the stimulus has stood
    assign sel_ev = stim_src == 2'h0 ? ev_trigger : stim_src == 2'h1 ? ev_window : stim_src == 2'h2 && ev_sequencer;
    assign halt_ev = halt_enable && (halt_src ? ev_mdone : ev_tpoint);
    // restart on release so a restarted pulse only lengthens the count
    always @(posedge mclk) begin
        if (srst || !stim_n_oe) begin
            run <= 16'h0000;
        end else begin
            run <= run + 16'h0001;
        end
    end
    property p_halt_set;
        halt_ev |=> halt_n_oe;
    endproperty
    a_halt_set: assert property (p_halt_set) else $error("halt not raised");
    property p_halt_hold;
        halt_n_oe && !trace_start |=> halt_n_oe;
    endproperty
    a_halt_hold: assert property (p_halt_hold) else $error("halt dropped");
    property p_halt_rel;
        trace_start && !halt_ev |=> !halt_n_oe;
    endproperty
    a_halt_rel: assert property (p_halt_rel) else $error("halt kept");
    property p_stim_off;
        !stim_enable |=> !stim_n_oe;
    endproperty
    a_stim_off: assert property (p_stim_off) else $error("stimulus leaked");
    property p_stim_set;
        sel_ev && stim_enable && stim_repeat && !trace_start |=> stim_n_oe;
    endproperty
    a_stim_set: assert property (p_stim_set) else $error("stimulus missed");
    property p_pulse_len;
        $fell(stim_n_oe) && !stim_handshake && $past(stim_enable) && !$past(trace_start) |-> run >= `BPC_PULSE_CYC;
    endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("pulse short");
    property p_hs_ack;
        stim_n_oe && stim_handshake && stim_repeat && !ack_n_in && !sel_ev |-> ##[1:4] !stim_n_oe;
    endproperty
    a_hs_ack: assert property (p_hs_ack) else $error("ack ignored");
    property p_hs_single;
        stim_n_oe && stim_handshake && !stim_repeat && stim_enable && !trace_start |=> stim_n_oe;
    endproperty
    a_hs_single: assert property (p_hs_single) else $error("held stimulus dropped");
endmodule
bind bpc_probe bpc_probe_monitor u_mon (.*);
`default_nettype wire

// >>> dv/tb.sv
// self-checking bench for the probe front end
`timescale 1ns/10ps
`default_nettype none
`include "bpc_defines.vh"
module tb;
    logic mclk, srst, stim_enable, stim_repeat, stim_handshake, halt_enable, halt_src, anl_ready, ack_on;
    logic [23:0] tgt_addr;
    logic [15:0] tgt_data;
    logic [11:0] tgt_user;
    logic [7:0] tgt_stat, tgt_clk, module_id;
    logic [3:0] clk_enable, clk_falling;
    logic [1:0] stim_src;
    logic [5:0] evs; // one-hot event pulses
    wire trace_start, ev_mdone, ev_tpoint, ev_sequencer, ev_window, ev_trigger, ack_n_in;
    wire halt_n_out, halt_n_oe, stim_n_out, stim_n_oe, anl_valid, cap_overflow, halt_active, stim_active;
    wire [67:0] anl_word;
    wire [7:0] probe_id, probe_module_id;
    wire halt_w; // open-collector wires with pull-ups
    wire stim_w;
    int num_errors, num_checks, tick;
    assign {trace_start, ev_mdone, ev_tpoint, ev_sequencer, ev_window, ev_trigger} = evs;
    assign halt_w = halt_n_oe ? halt_n_out : 1'b1;
    assign stim_w = stim_n_oe ? stim_n_out : 1'b1;
    bpc_probe DUT (.*);
    bpc_tgt_model u_tgt (.mclk(mclk), .ack_on(ack_on), .lag(8'hfa), .stim_w(stim_w), .ack_n(ack_n_in));
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    task cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task chk(input string s, input logic [67:0] g, input logic [67:0] e);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s exp %h got %h", s, e, g);
        end
    endtask
    // pulse: 0..2 stimulus sources, 3 trace point, 4 measurement done, 5 new trace
    task pls(input int s);
        @(posedge mclk) evs <= 6'h01 << s;
        @(posedge mclk) evs <= 6'h00;
    endtask
    // count cycles the stimulus stands, sampled at falling edges away from updates
    task hi(output int n);
        n = 0;
        @(negedge mclk);
        while (stim_n_oe === 1'b1 && n < 400) begin
            n++;
            @(negedge mclk);
        end
        @(posedge mclk); // drives resume on a rising edge
    endtask
    // one half period of the 200 ns link clock
    task lk(input int b, input logic v);
        @(posedge mclk) tgt_clk[b] <= v;
        cyc(3);
    endtask
    task word(input logic [23:0] a, input logic [7:0] st);
        cyc(12);
        chk("addr", anl_word[23:0], a);
        chk("stat", anl_word[59:52], st);
        chk("pass", {anl_word[67:60], anl_word[51:24]}, {tgt_clk, tgt_user, tgt_data});
    endtask
    // latched groups follow only their enabled, polarity-adjusted clocks
    task t_latch;
        clk_enable <= 4'hb;
        clk_falling <= 4'h2;
        tgt_addr <= 24'h5a_0f3c;
        tgt_stat <= 8'h96;
        tgt_data <= 16'h1e2d;
        tgt_user <= 12'h7b4;
        lk(0, 1'b1);
        lk(2, 1'b1);
        lk(2, 1'b0);
        tgt_addr <= 24'hc3_9601;
        word(24'h5a_0f3c, 8'h00);
        lk(3, 1'b1);
        word(24'h5a_0f3c, 8'h00);
        lk(3, 1'b0);
        word(24'hc3_9601, 8'h00);
        lk(5, 1'b1);
        tgt_stat <= 8'h3a;
        lk(4, 1'b1);
        word(24'hc3_9601, 8'h96);
        chk("id", probe_module_id, module_id);
        chk("probe id", probe_id, `BPC_PROBE_ID);
    endtask
    // stall the analyzer until the buffer refuses, then release it
    task t_fifo;
        anl_ready <= 1'b0;
        cyc(40);
        chk("full", {anl_valid, cap_overflow}, 2'h3);
        anl_ready <= 1'b1;
        cyc(30);
        pls(5);
        cyc(2);
        chk("ovf clr", cap_overflow, 1'b0);
    endtask
    task t_halt;
        pls(4);
        cyc(3);
        chk("halt off", halt_w, 1'b1);
        halt_enable <= 1'b1;
        halt_src <= 1'b1;
        pls(3);
        cyc(3);
        chk("halt src", halt_w, 1'b1);
        pls(4);
        cyc(30);
        chk("halt held", halt_w, 1'b0);
        chk("halt act", halt_active, 1'b1);
        pls(5);
        cyc(3);
        chk("halt rel", halt_w, 1'b1);
        halt_src <= 1'b0;
        pls(3);
        cyc(3);
        chk("halt tp", halt_w, 1'b0);
        pls(5);
    endtask
    task t_stim;
        int n;
        for (int s = 0; s < 3; s++) begin
            pls(s);
            hi(n);
            chk("blocked", n, 0);
        end
        stim_enable <= 1'b1;
        stim_repeat <= 1'b1;
        for (int s = 0; s < 3; s++) begin
            stim_src <= s[1:0];
            pls((s + 1) % 3);
            hi(n);
            chk("other src", n, 0);
            repeat (2) begin
                pls(s);
                hi(n);
                chk("pulse", n, `BPC_PULSE_CYC);
            end
        end
        // a second occurrence inside a pulse restarts its timer
        pls(2);
        cyc(100);
        pls(2);
        hi(n);
        chk("restart", n, `BPC_PULSE_CYC);
        // the unused source code selects nothing
        stim_src <= 2'h3;
        for (int s = 0; s < 3; s++) begin
            pls(s);
            hi(n);
            chk("no src", n, 0);
        end
        stim_src <= 2'h0;
        stim_repeat <= 1'b0;
        pls(5);
        for (int k = 0; k < 3; k++) begin
            if (k == 2) pls(5);
            pls(0);
            hi(n);
            chk("single", n, k == 1 ? 0 : `BPC_PULSE_CYC);
        end
        stim_handshake <= 1'b1;
        stim_repeat <= 1'b1;
        ack_on <= 1'b1;
        repeat (2) begin
            pls(0);
            hi(n);
            chk("acked", n >= 250 && n < 260, 1'b1);
        end
        stim_repeat <= 1'b0;
        pls(5);
        pls(0);
        cyc(300);
        chk("sticky", stim_w, 1'b0);
        chk("stim act", stim_active, 1'b1);
        pls(5);
        cyc(3);
        chk("released", stim_w, 1'b1);
        chk("stim idle", stim_active, 1'b0);
    endtask
    task results;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // cut a hang short well past the expected run length
    always @(posedge mclk) begin
        tick++;
        if (tick == 10000) begin
            num_errors++;
            results;
        end
    end
    initial begin
        {evs, tgt_addr, tgt_data, tgt_user, tgt_stat, tgt_clk, clk_enable, clk_falling, stim_src} = '0;
        {stim_enable, stim_repeat, stim_handshake, halt_enable, halt_src, ack_on} = '0;
        srst = 1'b1;
        anl_ready = 1'b1;
        module_id = 8'h3c;
        cyc(16);
        srst <= 1'b0;
        t_latch;
        t_fifo;
        t_halt;
        t_stim;
        results;
    end
endmodule
`default_nettype wire
